//--- rtl/fcs_ctrl_status.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_ctrl_status #(
  parameter logic [1:0] RN_CODE = fcs_pkg::RND_NEAREST_CODE,
  parameter logic [1:0] RZ_CODE = fcs_pkg::RND_ZERO_CODE,
  parameter logic [1:0] RP_CODE = fcs_pkg::RND_POS_CODE,
  parameter logic [1:0] RM_CODE = fcs_pkg::RND_NEG_CODE
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_n_i,
  // Controls
  input wire logic result_stage_bypass_i,
  input wire logic round_mode_sel_0_i,
  input wire logic round_mode_sel_1_i,
  input wire logic result_half_select_i,
  input wire logic [fcs_pkg::OPSEL_W-1:0] operand_source_select_i,
  input wire logic status_source_select_0_i,
  input wire logic status_source_select_1_i,
  input wire logic c_reg_source_select_i,
  // Unit results and operand class
  input wire fcs_pkg::fcs_res_s mul_res_i,
  input wire fcs_pkg::fcs_res_s alu_res_i,
  input wire logic a_nan_i,
  input wire logic a_denorm_i,
  input wire logic b_nan_i,
  input wire logic b_denorm_i,
  // Operand routing and rounding mode
  output logic [fcs_pkg::OPSEL_W-1:0] mul_operand_sel_o,
  output logic [fcs_pkg::OPSEL_W-1:0] alu_operand_sel_o,
  output fcs_pkg::fcs_rnd_e round_mode_o,
  // Y bus
  output logic [fcs_pkg::Y_W-1:0] y_o,
  output logic y_oe_n_o,
  output logic [fcs_pkg::PAR_W-1:0] y_parity_o,
  // C register
  output logic [fcs_pkg::RES_W-1:0] c_reg_o,
  // Status
  output logic round_carry_flag_o,
  output logic underflow_flag_o,
  output logic unordered_compare_flag_o,
  output logic a_port_input_exception_o,
  output logic b_port_input_exception_o,
  output logic status_origin_flag_o
);

  // Module state, apart from the P and S result registers
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] byp_sync;
    fcs_pkg::fcs_stat_s stat_hold; // Status register stage
    logic origin_hold; // Origin bit of the stage
    fcs_pkg::fcs_stat_s stat;
    logic origin;
    fcs_pkg::fcs_rnd_e rnd;
    logic [fcs_pkg::OPSEL_W-1:0] msel;
    logic [fcs_pkg::OPSEL_W-1:0] asel;
    logic [fcs_pkg::Y_W-1:0] y;
    logic [fcs_pkg::PAR_W-1:0] par;
    logic [fcs_pkg::RES_W-1:0] c;
    logic y_oe_n; // Y drive enable, low drives
  } fcs_state_s;

  fcs_state_s st;
  fcs_state_s next_st;

  // Result registers, P and S
  logic [fcs_pkg::RES_W-1:0] p_q;
  logic [fcs_pkg::RES_W-1:0] s_q;
  // Live unit status and selected result
  fcs_pkg::fcs_stat_s mul_stat;
  fcs_pkg::fcs_stat_s alu_stat;
  fcs_pkg::fcs_stat_s sel_stat;
  logic sel_mul;
  logic [1:0] ssel;
  logic [1:0] rsel;
  logic [fcs_pkg::RES_W-1:0] res;
  logic [fcs_pkg::Y_W-1:0] y_half;
  logic byp;
  // Status after the stage, flowthrough or held
  fcs_pkg::fcs_stat_s stage_stat;
  logic stage_origin;

  assign byp = st.byp_sync[1];

  // Product register
  fcs_stage_reg #(.W(fcs_pkg::RES_W)) u_p_reg (
    .clk_i(clk_i),
    .bypass_i(byp),
    .load_i(1'b1),
    .d_i(mul_res_i.value),
    .q_o(p_q)
  );

  // Sum register
  fcs_stage_reg #(.W(fcs_pkg::RES_W)) u_s_reg (
    .clk_i(clk_i),
    .bypass_i(byp),
    .load_i(1'b1),
    .d_i(alu_res_i.value),
    .q_o(s_q)
  );

  // Per-unit status derivation
  always_comb begin
    // Multiplier flags
    mul_stat.rnd_carry = mul_res_i.wrapped & mul_res_i.rnd_up;
    mul_stat.under = mul_res_i.inexact & mul_res_i.tiny;
    mul_stat.unordered_compare_flag = a_nan_i | b_nan_i;
    mul_stat.exc_a = a_nan_i | a_denorm_i;
    mul_stat.exc_b = b_nan_i | b_denorm_i;
    // ALU flags
    alu_stat.rnd_carry = alu_res_i.wrapped & alu_res_i.rnd_up;
    alu_stat.under = alu_res_i.inexact & alu_res_i.tiny;
    alu_stat.unordered_compare_flag = a_nan_i | b_nan_i;
    alu_stat.exc_a = a_nan_i | a_denorm_i;
    alu_stat.exc_b = b_nan_i | b_denorm_i;
  end

  // Status source choice
  always_comb begin
    ssel = {status_source_select_1_i, status_source_select_0_i};
    sel_mul = (ssel == fcs_pkg::STSRC_MUL);
    sel_stat = sel_mul ? mul_stat : alu_stat;
    res = c_reg_source_select_i ? p_q : s_q;
    y_half = result_half_select_i ? res[fcs_pkg::RES_W-1:fcs_pkg::Y_W]
                                  : res[fcs_pkg::Y_W-1:0];
    rsel = {round_mode_sel_1_i, round_mode_sel_0_i};
  end

  // Status register stage; flowthrough when bypassed so flags track P and S
  always_comb begin
    stage_stat = byp ? sel_stat : st.stat_hold;
    stage_origin = byp ? sel_mul : st.origin_hold;
  end

  // Next state
  always_comb begin
    next_st = st;
    next_st.rst_sync = {st.rst_sync[0], ~reset_n_i};
    next_st.byp_sync = {st.byp_sync[0], result_stage_bypass_i};
    // Rounding mode decode through parameters
    if (rsel == RN_CODE) begin
      next_st.rnd = fcs_pkg::FCS_RN;
    end else if (rsel == RZ_CODE) begin
      next_st.rnd = fcs_pkg::FCS_RZ;
    end else if (rsel == RP_CODE) begin
      next_st.rnd = fcs_pkg::FCS_RP;
    end else begin
      next_st.rnd = fcs_pkg::FCS_RM;
    end
    // Operand routing: whole code goes to both units, encodings left open
    next_st.msel = operand_source_select_i;
    next_st.asel = operand_source_select_i;
    // Status: stage register, then output flops; reset clears both
    if (st.rst_sync[1]) begin
      next_st.stat_hold = '0;
      next_st.origin_hold = 1'b0;
      next_st.stat = '0;
      next_st.origin = 1'b0;
    end else begin
      next_st.stat_hold = sel_stat;
      next_st.origin_hold = sel_mul;
      next_st.stat = stage_stat;
      next_st.origin = stage_origin;
    end
    // Y bus and parity per byte
    next_st.y = y_half;
    next_st.y_oe_n = 1'b0;
    for (int i = 0; i < int'(fcs_pkg::PAR_W); i++) begin
      next_st.par[i] = ^y_half[i*8 +: 8];
    end
    // C register holds data through device reset; rst_i clears it
    next_st.c = res;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign mul_operand_sel_o = st.msel;
  assign alu_operand_sel_o = st.asel;
  assign round_mode_o = st.rnd;
  assign y_o = st.y;
  assign y_oe_n_o = st.y_oe_n;
  assign y_parity_o = st.par;
  assign c_reg_o = st.c;
  assign round_carry_flag_o = st.stat.rnd_carry;
  assign underflow_flag_o = st.stat.under;
  assign unordered_compare_flag_o = st.stat.unordered_compare_flag;
  assign a_port_input_exception_o = st.stat.exc_a;
  assign b_port_input_exception_o = st.stat.exc_b;
  assign status_origin_flag_o = st.origin;

  // Checks: Y bus and parity
  AST_HALF_HI: assert property (@(posedge clk_i) disable iff (rst_i)
    result_half_select_i |=> y_o == $past(res[fcs_pkg::RES_W-1:fcs_pkg::Y_W]))
    else $error("y half select wrong");
  AST_HALF_LO: assert property (@(posedge clk_i) disable iff (rst_i)
    !result_half_select_i |=> y_o == $past(res[fcs_pkg::Y_W-1:0]))
    else $error("y lower half wrong");
  AST_PAR: assert property (@(posedge clk_i) disable iff (rst_i)
    y_parity_o[0] == ^y_o[7:0])
    else $error("parity mismatch");
  AST_PAR_ALL: assert property (@(posedge clk_i) disable iff (rst_i)
    y_parity_o == {^y_o[31:24], ^y_o[23:16], ^y_o[15:8], ^y_o[7:0]})
    else $error("parity of upper bytes wrong");
  // Checks: device reset
  AST_RST_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    st.rst_sync[1] |=> !round_carry_flag_o && !status_origin_flag_o)
    else $error("reset did not clear status");
  AST_RST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    st.rst_sync[1] |=> st.stat_hold == '0 && !st.origin_hold)
    else $error("reset did not clear status stage");
  AST_RST_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
    st.rst_sync[1] && !byp ##1 !byp |-> p_q == $past(mul_res_i.value))
    else $error("reset disturbed product register");
  // Checks: status stage
  AST_BYP_STAT: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.rst_sync[1] && byp |=> round_carry_flag_o == $past(sel_stat.rnd_carry))
    else $error("status not flowthrough under bypass");
  AST_HOLD_STAT: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.rst_sync[1] && !byp |=> underflow_flag_o == $past(st.stat_hold.under))
    else $error("status stage skipped");
  // Checks: flag sources
  AST_ORIGIN: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.rst_sync[1] && byp && sel_mul |=> status_origin_flag_o)
    else $error("origin flag wrong");
  AST_ORIGIN_ALU: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.rst_sync[1] && byp && !sel_mul |=> !status_origin_flag_o)
    else $error("origin flag not low for ALU");
  AST_CARRY: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.rst_sync[1] && byp && sel_mul && mul_res_i.wrapped && mul_res_i.rnd_up
    |=> round_carry_flag_o)
    else $error("round carry missing");
  AST_CARRY_NOT: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.rst_sync[1] && byp && !sel_mul && !alu_res_i.wrapped |=> !round_carry_flag_o)
    else $error("round carry without wrap");
  AST_UNDER: assert property (@(posedge clk_i) disable iff (rst_i)
    underflow_flag_o |-> $past(stage_stat.under))
    else $error("underflow without cause");
  AST_UNDER_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.rst_sync[1] && byp && sel_mul && mul_res_i.inexact && mul_res_i.tiny
    |=> underflow_flag_o)
    else $error("underflow missing");
  AST_UNORDERED_COMPARE_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.rst_sync[1] && byp && a_nan_i |=> unordered_compare_flag_o)
    else $error("unordered missing");
  AST_UNORDERED_COMPARE_FLAG_NOT: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.rst_sync[1] && byp && !a_nan_i && !b_nan_i |=> !unordered_compare_flag_o)
    else $error("unordered without NaN");
  AST_EXC_A: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.rst_sync[1] && byp && a_denorm_i |=> a_port_input_exception_o)
    else $error("a exception missing");
  AST_EXC_B: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.rst_sync[1] && !byp && b_denorm_i ##1 !st.rst_sync[1] && !byp
    |=> b_port_input_exception_o)
    else $error("b exception missing");
  // Checks: routing and rounding
  AST_CSRC: assert property (@(posedge clk_i) disable iff (rst_i)
    c_reg_source_select_i && byp |=> c_reg_o == $past(mul_res_i.value))
    else $error("c source wrong");
  AST_CSRC_ALU: assert property (@(posedge clk_i) disable iff (rst_i)
    !c_reg_source_select_i && byp |=> c_reg_o == $past(alu_res_i.value))
    else $error("c source ALU wrong");
  AST_OPSEL: assert property (@(posedge clk_i) disable iff (rst_i)
    operand_source_select_i != 8'h00 |=>
    mul_operand_sel_o == $past(operand_source_select_i) &&
    alu_operand_sel_o == $past(operand_source_select_i))
    else $error("operand select not routed");
  AST_RND: assert property (@(posedge clk_i) disable iff (rst_i)
    rsel == RZ_CODE |=> round_mode_o == fcs_pkg::FCS_RZ)
    else $error("round mode wrong");
  AST_RND_RN: assert property (@(posedge clk_i) disable iff (rst_i)
    rsel == RN_CODE |=> round_mode_o == fcs_pkg::FCS_RN)
    else $error("nearest mode wrong");
  AST_RND_RP: assert property (@(posedge clk_i) disable iff (rst_i)
    rsel == RP_CODE |=> round_mode_o == fcs_pkg::FCS_RP)
    else $error("plus mode wrong");
  AST_RND_RM: assert property (@(posedge clk_i) disable iff (rst_i)
    rsel == RM_CODE |=> round_mode_o == fcs_pkg::FCS_RM)
    else $error("minus mode wrong");
  // Covers for the main scenarios
  COV_BYP: cover property (@(posedge clk_i) byp && c_reg_source_select_i);
  COV_RST: cover property (@(posedge clk_i) st.rst_sync[1]);
  COV_UNORDERED_COMPARE_FLAG: cover property (@(posedge clk_i) unordered_compare_flag_o);
  COV_HOLD: cover property (@(posedge clk_i) !byp && st.stat_hold.exc_b);
  COV_HALF: cover property (@(posedge clk_i) result_half_select_i && byp);

endmodule : fcs_ctrl_status
`default_nettype wire

//--- rtl/fcs_stage_reg.sv
`timescale 1ns/1ps
`default_nettype none
// Result register with flowthrough bypass
module fcs_stage_reg #(
  parameter int unsigned W = 64
) (
  // Clock
  input wire logic clk_i,
  // Control
  input wire logic bypass_i,
  input wire logic load_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // Registered copy
  logic [W-1:0] held;

  // Held value changes only on load, never on reset
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      held <= d_i;
    end
  end

  // Flowthrough when bypassed
  always_comb begin
    q_o = bypass_i ? d_i : held;
  end

endmodule : fcs_stage_reg
`default_nettype wire

//--- shared/fcs_pkg.sv
package fcs_pkg;

  // Data widths
  localparam int unsigned Y_W = 32;
  localparam int unsigned RES_W = 64;
  localparam int unsigned PAR_W = 4;
  localparam int unsigned OPSEL_W = 8;

  // Rounding mode codes (assignment kept open as parameters)
  localparam logic [1:0] RND_NEAREST_CODE = 2'h0;
  localparam logic [1:0] RND_ZERO_CODE = 2'h1;
  localparam logic [1:0] RND_POS_CODE = 2'h2;
  localparam logic [1:0] RND_NEG_CODE = 2'h3;

  // Status source codes
  localparam logic [1:0] STSRC_ALU = 2'h0;
  localparam logic [1:0] STSRC_MUL = 2'h1;

  // Reset values
  localparam logic [RES_W-1:0] RES_RST = 64'h0;

  // Rounding modes
  typedef enum logic [1:0] {
    FCS_RN = 2'b00,
    FCS_RZ = 2'b01,
    FCS_RP = 2'b10,
    FCS_RM = 2'b11
  } fcs_rnd_e;

  // Status word of one unit
  typedef struct packed {
    logic rnd_carry;
    logic under;
    logic unordered_compare_flag;
    logic exc_a;
    logic exc_b;
  } fcs_stat_s;

  // Raw result from one unit
  typedef struct packed {
    logic [RES_W-1:0] value;
    logic inexact;
    logic tiny;
    logic rnd_up;
    logic wrapped;
  } fcs_res_s;

endpackage : fcs_pkg

//--- tb/fcs_ctrl_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_ctrl_status_tb;
  // One table row: inputs then expected y and flags
  typedef struct packed {
    logic byp; logic half; logic csrc; logic [1:0] ss; logic [1:0] rnd;
    logic [3:0] mf; logic [3:0] af; logic [3:0] cls; logic [31:0] ey; logic [5:0] ef;
  } fcs_row_s;
  localparam fcs_row_s ROWS [4] = '{
    '{1'h1, 1'h0, 1'h1, 2'h1, 2'h0, 4'hf, 4'h0, 4'h0, 32'h76543210, 6'h31},
    '{1'h1, 1'h1, 1'h0, 2'h0, 2'h1, 4'hf, 4'h8, 4'h8, 32'h01234567, 6'h0c},
    '{1'h0, 1'h1, 1'h1, 2'h2, 2'h2, 4'h0, 4'h3, 4'h1, 32'hfedcba98, 6'h22},
    '{1'h0, 1'h0, 1'h0, 2'h3, 2'h3, 4'h2, 4'h4, 4'h6, 32'h89abcdef, 6'h0e}};
  logic clk_i, rst_i, reset_n_i, byp, half, csrc, inv;
  logic [1:0] ss, rnd;
  logic [3:0] mf, af, cls;
  logic [7:0] opsel, mos, aos;
  fcs_pkg::fcs_res_s mres, ares;
  fcs_pkg::fcs_rnd_e rmode;
  logic [31:0] y;
  logic [3:0] par_o;
  logic [63:0] creg;
  logic oe_n, f_c, f_u, f_o, f_a, f_b, f_s;
  int fail_count, comparisons, cycles;
  fcs_host_model u_fcs_host_model (.inv_i(inv), .mflg_i(mf), .aflg_i(af),
    .mul_res_o(mres), .alu_res_o(ares));
  fcs_ctrl_status u_fcs_ctrl_status (.clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
    .result_stage_bypass_i(byp), .round_mode_sel_0_i(rnd[0]), .round_mode_sel_1_i(rnd[1]),
    .result_half_select_i(half), .operand_source_select_i(opsel),
    .status_source_select_0_i(ss[0]), .status_source_select_1_i(ss[1]),
    .c_reg_source_select_i(csrc), .mul_res_i(mres), .alu_res_i(ares),
    .a_nan_i(cls[3]), .a_denorm_i(cls[2]), .b_nan_i(cls[1]), .b_denorm_i(cls[0]),
    .mul_operand_sel_o(mos), .alu_operand_sel_o(aos), .round_mode_o(rmode),
    .y_o(y), .y_oe_n_o(oe_n), .y_parity_o(par_o), .c_reg_o(creg),
    .round_carry_flag_o(f_c), .underflow_flag_o(f_u), .unordered_compare_flag_o(f_o),
    .a_port_input_exception_o(f_a), .b_port_input_exception_o(f_b),
    .status_origin_flag_o(f_s));
  // Clock, 4 ns period
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 500) begin
      fail_count++;
      complete_run();
    end
  end
  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Even-sense parity per byte
  function automatic logic [3:0] par(input logic [31:0] v);
    for (int i = 0; i < 4; i++) par[i] = ^v[8*i+:8];
  endfunction : par
  // Verdict
  task automatic complete_run();
    $display("fails=%0d checks=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    {rst_i, reset_n_i, byp, half, csrc, inv, ss, rnd, mf, af, cls, opsel} = '0;
    rst_i = 1'b1;
    reset_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    chk({f_c, f_u, f_o, f_a, f_b, f_s}, 0);
    chk(oe_n, 0);
    // Table cases, held long enough for any path
    foreach (ROWS[i]) begin
      {byp, half, csrc, ss, rnd, mf, af, cls} = ROWS[i][56:38];
      opsel = 8'ha5 ^ 8'(i);
      repeat (3) @(negedge clk_i);
      chk(y, ROWS[i].ey);
      chk(par_o, par(ROWS[i].ey));
      chk({f_c, f_u, f_o, f_a, f_b, f_s}, ROWS[i].ef);
      chk(rmode, ROWS[i].rnd);
      chk({mos, aos}, {opsel, opsel});
      chk(creg, csrc ? mres.value : ares.value);
    end
    // Device reset clears status, keeps data
    reset_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk({f_c, f_u, f_o, f_a, f_b, f_s}, 0);
    chk(creg, 64'h0123456789abcdef);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk({f_c, f_u, f_o, f_a, f_b, f_s}, 6'h0e);
    // Flowthrough: data change shows one cycle sooner
    byp = 1'b1;
    repeat (3) @(negedge clk_i);
    inv = 1'b1;
    af = 4'h3;
    @(negedge clk_i);
    chk(y, 32'h76543210);
    chk({f_c, f_u, f_o, f_a, f_b, f_s}, 6'h2e);
    byp = 1'b0;
    repeat (3) @(negedge clk_i);
    inv = 1'b0;
    af = 4'h4;
    @(negedge clk_i);
    chk(y, 32'h76543210);
    chk({f_c, f_u, f_o, f_a, f_b, f_s}, 6'h2e);
    @(negedge clk_i);
    chk(y, 32'h89abcdef);
    chk({f_c, f_u, f_o, f_a, f_b, f_s}, 6'h0e);
    complete_run();
  end
endmodule : fcs_ctrl_status_tb
`default_nettype wire

//--- tb/fcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Datapath stand-in feeding fixed unit results
module fcs_host_model (
  // Controls
  input wire logic inv_i,
  input wire logic [3:0] mflg_i,
  input wire logic [3:0] aflg_i,
  // Unit results
  output fcs_pkg::fcs_res_s mul_res_o,
  output fcs_pkg::fcs_res_s alu_res_o
);
  // Fixed values tell halves and units apart; inv flips data
  assign mul_res_o = {64'hfedcba9876543210 ^ {64{inv_i}}, mflg_i};
  assign alu_res_o = {64'h0123456789abcdef ^ {64{inv_i}}, aflg_i};
endmodule : fcs_host_model
`default_nettype wire
